// ---- rtl/psru_top.sv ----
// packed shift right execution unit with fault checks
// assumes decode hands one instruction per issue pulse with operands
`timescale 1ns/1ns
`default_nettype none
`include "psru_consts.svh"

// How it works
// - arithmetic word shift: four 16-bit lanes, sign-filled from the top.
// - arithmetic dword shift: two 32-bit lanes, sign-filled from the top.
// - arithmetic count above lane max gives all sign copies per lane.
// - logical word shift: four 16-bit lanes, zero-filled.
// - logical dword shift: two 32-bit lanes, zero-filled independently.
// - logical quad shift: whole 64 bits as one lane, zero-filled.
// - logical count above 15, 31 or 63 clears the result.
// - immediate forms use 8-bit count, else 64-bit operand; result to dest.
// - arithmetic forms chosen by opcode E1/E2 and groups 71/72 reg 4.
// - logical forms chosen by D1/D2/D3 and groups 71/72/73 reg 2.
// - emulation bit set raises invalid opcode instead of executing.
// - task switched gives device unavailable; pending float error faults.
// - protected bad address: general protection or stack fault, code 0.
// - protected page miss faults with code; user unaligned faults.
// - real mode operand beyond 0FFFFH raises interrupt 13.
module psru_top
    import psru_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        issue,
    input  wire logic [7:0]  opcode,
    input  wire logic [2:0]  modrm_reg,
    input  wire logic [2:0]  dest_idx,
    input  wire logic [63:0] dest_val,
    input  wire logic [63:0] src_val,
    input  wire logic [7:0]  immediate_count,
    input  wire logic        src_is_mem,
    input  wire logic        emulation_bit,
    input  wire logic        task_switched_flag,
    input  wire logic        float_pending,
    input  wire logic        protected_mode,
    input  wire logic        seg_limit_bad,
    input  wire logic        seg_is_stack,
    input  wire logic        page_miss,
    input  wire logic [31:0] page_code,
    input  wire logic        unaligned,
    input  wire logic        align_check_en,
    input  wire logic [1:0]  cpl,
    input  wire logic [31:0] mem_eaddr,
    output logic             done,
    output logic             wr_en,
    output logic [2:0]       wr_idx,
    output logic [63:0]      wr_data,
    output logic             fault,
    output logic [7:0]       fault_vec,
    output logic             fault_has_code,
    output logic [31:0]      fault_code
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        psru_state_t st;
        logic [2:0]  idx;
        logic [63:0] data;
        logic [7:0]  vec;
        logic        has_code;
        logic [31:0] code;
    } psru_regs_t;

    psru_regs_t r_q;
    psru_regs_t r_d;

    psru_op_t    op;
    logic        use_imm;
    logic [6:0]  cnt;
    logic [63:0] shifted;
    logic [32:0] last_byte;

    psru_decode u_decode
    (
        .opcode    (opcode),
        .modrm_reg (modrm_reg),
        .op        (op),
        .use_imm   (use_imm)
    );

    // ------------------------------------------------------------
    // count selection and saturation
    // ------------------------------------------------------------
    always_comb
    begin
        if (use_imm)
            cnt = (immediate_count > 8'd64) ? 7'd64
                : immediate_count[6:0];
        else if (|src_val[63:7] || src_val[6:0] > 7'd64)
            cnt = 7'd64;
        else
            cnt = src_val[6:0];
    end

    psru_shifter u_shifter
    (
        .src (dest_val),
        .cnt (cnt),
        .op  (op),
        .res (shifted)
    );

    assign last_byte = {1'b0, mem_eaddr} + 33'd7;

    // ------------------------------------------------------------
    // fault priority and result capture
    // ------------------------------------------------------------
    always_comb
    begin
        r_d          = r_q;
        r_d.st       = PSRU_IDLE;
        r_d.has_code = 1'b0;
        r_d.code     = 32'h0;
        if (issue)
        begin
            r_d.st  = PSRU_FAULT;
            r_d.idx = dest_idx;
            if (op == PSRU_NONE || emulation_bit)
                r_d.vec = `PSRU_VEC_INVALID;
            else if (task_switched_flag)
                r_d.vec = `PSRU_VEC_NODEV;
            else if (float_pending)
                r_d.vec = `PSRU_VEC_FLOAT;
            else if (src_is_mem && !use_imm && !protected_mode
                     && last_byte > {1'b0, `PSRU_RM_LIMIT})
                r_d.vec = `PSRU_VEC_PROT;
            else if (src_is_mem && !use_imm && protected_mode
                     && seg_limit_bad)
            begin
                r_d.vec      = seg_is_stack ? `PSRU_VEC_STACK
                             : `PSRU_VEC_PROT;
                r_d.has_code = 1'b1;
                r_d.code     = 32'h0;
            end
            else if (src_is_mem && !use_imm && protected_mode
                     && page_miss)
            begin
                r_d.vec      = `PSRU_VEC_PAGE;
                r_d.has_code = 1'b1;
                r_d.code     = page_code;
            end
            else if (src_is_mem && !use_imm && protected_mode
                     && unaligned && align_check_en
                     && cpl == `PSRU_CPL_USER)
            begin
                r_d.vec      = `PSRU_VEC_ALIGN;
                r_d.has_code = 1'b1;
                r_d.code     = 32'h0;
            end
            else
            begin
                r_d.st   = PSRU_DONE;
                r_d.data = shifted;
                r_d.vec  = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign done           = (r_q.st != PSRU_IDLE);
    assign wr_en          = (r_q.st == PSRU_DONE);
    assign wr_idx         = r_q.idx;
    assign wr_data        = r_q.data;
    assign fault          = (r_q.st == PSRU_FAULT);
    assign fault_vec      = r_q.vec;
    assign fault_has_code = r_q.has_code;
    assign fault_code     = r_q.code;

endmodule
`default_nettype wire

// ---- rtl/psru_consts.svh ----
// constants for the packed shift right unit: opcodes, fault vectors
// assumes nothing beyond a SystemVerilog compiler
`ifndef PSRU_CONSTS_SVH
`define PSRU_CONSTS_SVH

// ----------------------------------------------------------------
// opcode second bytes (after the 0F escape)
// ----------------------------------------------------------------
`define PSRU_ESC_BYTE      8'h0F
`define PSRU_OP_SRAW_R     8'hE1
`define PSRU_OP_SRAD_R     8'hE2
`define PSRU_OP_SRLW_R     8'hD1
`define PSRU_OP_SRLD_R     8'hD2
`define PSRU_OP_SRLQ_R     8'hD3
`define PSRU_OP_GRP_W      8'h71
`define PSRU_OP_GRP_D      8'h72
`define PSRU_OP_GRP_Q      8'h73
`define PSRU_REG_ARITH     3'h4
`define PSRU_REG_LOGIC     3'h2

// ----------------------------------------------------------------
// lane widths and fault vectors
// ----------------------------------------------------------------
`define PSRU_W_MAX         7'h0F
`define PSRU_D_MAX         7'h1F
`define PSRU_Q_MAX         7'h3F
`define PSRU_VEC_INVALID   8'h06
`define PSRU_VEC_NODEV     8'h07
`define PSRU_VEC_STACK     8'h0C
`define PSRU_VEC_PROT      8'h0D
`define PSRU_VEC_PAGE      8'h0E
`define PSRU_VEC_FLOAT     8'h10
`define PSRU_VEC_ALIGN     8'h11
`define PSRU_RM_LIMIT      32'h0000FFFF
`define PSRU_CPL_USER      2'h3

`endif

// ---- rtl/psru_pkg.sv ----
// types for the packed shift right unit
// assumes the constants header is also on the include path
package psru_pkg;

    typedef enum logic [2:0]
    {
        PSRU_NONE  = 3'b000,
        PSRU_SRAW  = 3'b001,
        PSRU_SRAD  = 3'b010,
        PSRU_SRLW  = 3'b011,
        PSRU_SRLD  = 3'b100,
        PSRU_SRLQ  = 3'b101
    } psru_op_t;

    typedef enum logic [1:0]
    {
        PSRU_IDLE  = 2'b00,
        PSRU_DONE  = 2'b01,
        PSRU_FAULT = 2'b10
    } psru_state_t;

endpackage

// ---- rtl/psru_decode.sv ----
// opcode decoder for the packed right shifts
// assumes the second opcode byte follows the 0F escape already
`timescale 1ns/1ns
`default_nettype none
`include "psru_consts.svh"

module psru_decode
    import psru_pkg::*;
(
    input  wire logic [7:0] opcode,
    input  wire logic [2:0] modrm_reg,
    output psru_op_t        op,
    output logic            use_imm
);

    always_comb
    begin
        op      = PSRU_NONE;
        use_imm = 1'b0;
        case (opcode)
            `PSRU_OP_SRAW_R: op = PSRU_SRAW;
            `PSRU_OP_SRAD_R: op = PSRU_SRAD;
            `PSRU_OP_SRLW_R: op = PSRU_SRLW;
            `PSRU_OP_SRLD_R: op = PSRU_SRLD;
            `PSRU_OP_SRLQ_R: op = PSRU_SRLQ;
            `PSRU_OP_GRP_W, `PSRU_OP_GRP_D, `PSRU_OP_GRP_Q:
            begin
                use_imm = 1'b1;
                if (modrm_reg == `PSRU_REG_ARITH)
                begin
                    if (opcode == `PSRU_OP_GRP_W)
                        op = PSRU_SRAW;
                    else if (opcode == `PSRU_OP_GRP_D)
                        op = PSRU_SRAD;
                end
                else if (modrm_reg == `PSRU_REG_LOGIC)
                begin
                    if (opcode == `PSRU_OP_GRP_W)
                        op = PSRU_SRLW;
                    else if (opcode == `PSRU_OP_GRP_D)
                        op = PSRU_SRLD;
                    else
                        op = PSRU_SRLQ;
                end
            end
            default: op = PSRU_NONE;
        endcase
        if (op == PSRU_NONE)
            use_imm = 1'b0;
    end

endmodule
`default_nettype wire

// ---- rtl/psru_shifter.sv ----
// combinational packed right shifter, one lane per generate entry
// assumes the count is already saturated to 0..64
`timescale 1ns/1ns
`default_nettype none

module psru_shifter
    import psru_pkg::*;
(
    input  wire logic [63:0] src,
    input  wire logic [6:0]  cnt,
    input  wire psru_op_t    op,
    output logic [63:0]      res
);

    logic [63:0] res_w;
    logic [63:0] res_d;
    logic        arith;

    assign arith = (op == PSRU_SRAW) || (op == PSRU_SRAD);

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_word
            logic [15:0] ln;
            logic        fill;
            logic [4:0]  c;
            assign ln   = src[16*g +: 16];
            assign fill = arith & ln[15];
            // counts over 15 give all fill bits
            assign c    = (cnt > 7'd15) ? 5'd16 : cnt[4:0];
            assign res_w[16*g +: 16] = 16'(
                ({{16{fill}}, ln} >> c));
        end
        for (g = 0; g < 2; g++)
        begin : g_dword
            logic [31:0] ln;
            logic        fill;
            logic [5:0]  c;
            assign ln   = src[32*g +: 32];
            assign fill = arith & ln[31];
            assign c    = (cnt > 7'd31) ? 6'd32 : cnt[5:0];
            assign res_d[32*g +: 32] = 32'(
                ({{32{fill}}, ln} >> c));
        end
    endgenerate

    always_comb
    begin
        case (op)
            PSRU_SRAW, PSRU_SRLW: res = res_w;
            PSRU_SRAD, PSRU_SRLD: res = res_d;
            PSRU_SRLQ:
                res = (cnt > 7'd63) ? 64'h0 : (src >> cnt[5:0]);
            default:              res = src;
        endcase
    end

endmodule
`default_nettype wire

// ---- dv/psru_properties.sv ----
// checker for the packed shift right unit, bound to psru_top
// assumes one issue per cycle and a registered one-cycle answer
`timescale 1ns/1ns
`default_nettype none
module psru_properties
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        issue,
    input wire logic [7:0]  opcode,
    input wire logic [2:0]  dest_idx,
    input wire logic [63:0] src_val,
    input wire logic        src_is_mem,
    input wire logic        emulation_bit,
    input wire logic        task_switched_flag,
    input wire logic        float_pending,
    input wire logic        done,
    input wire logic        wr_en,
    input wire logic [2:0]  wr_idx,
    input wire logic [63:0] wr_data,
    input wire logic        fault,
    input wire logic [7:0]  fault_vec,
    input wire logic        fault_has_code,
    input wire logic [31:0] fault_code
);
    // ------------------------------------------------------------
    // answer timing and fault checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_done_after_issue: assert property (issue |=> done)
        else $error("done missing after issue");
    a_no_spurious_done: assert property (!issue |=> !done && !wr_en && !fault)
        else $error("output pulse without issue");
    a_one_outcome: assert property (done |-> wr_en != fault)
        else $error("done without exactly one outcome");
    a_emul_invalid: assert property (issue && emulation_bit
        |=> fault && fault_vec == 8'h06) else $error("emulation not faulted");
    a_task_unavail: assert property (issue && !emulation_bit
        && task_switched_flag |=> fault && fault_vec == 8'h07)
        else $error("task switch not faulted");
    a_float_error: assert property (issue && !emulation_bit
        && !task_switched_flag && float_pending |=> fault_vec == 8'h10)
        else $error("pending float error not faulted");
    a_wr_index: assert property
        (issue ##1 wr_en |-> wr_idx == $past(dest_idx))
        else $error("write index differs from destination");
    a_quad_clear: assert property (issue && opcode == 8'hD3 && !src_is_mem
        && src_val > 64'h3F && !emulation_bit && !task_switched_flag
        && !float_pending |=> wr_en && wr_data == 64'h0)
        else $error("oversize quad shift not cleared");
    a_stack_code: assert property (fault && fault_vec == 8'h0C
        |-> fault_has_code && fault_code == 32'h0)
        else $error("stack fault code not zero");
    c_quad: cover property (issue && opcode == 8'hD3);
    c_fault: cover property (fault);
    c_write: cover property (wr_en);
endmodule
bind psru_top psru_properties i_props (.clk, .arst_n, .issue, .opcode,
    .dest_idx, .src_val, .src_is_mem, .emulation_bit, .task_switched_flag,
    .float_pending, .done, .wr_en, .wr_idx, .wr_data, .fault, .fault_vec,
    .fault_has_code, .fault_code);
`default_nettype wire

// ---- dv/psru_rf_model.sv ----
// register file stand-in: keeps what the unit writes back
// assumes the unit's write pulse lasts one cycle
`timescale 1ns/1ns
`default_nettype none
module psru_rf_model
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        wr_en,
    input wire logic [2:0]  wr_idx,
    input wire logic [63:0] wr_data
);
    logic [63:0] regs_q [8];
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            regs_q <= '{default: 64'h0};
        else if (wr_en)
            regs_q[wr_idx] <= wr_data;
    end
endmodule
`default_nettype wire

// ---- dv/packed_shift_right_unit_tb.sv ----
// testbench for the packed shift right unit
// assumes psru_top with register file model and bound checker
`timescale 1ns/1ns
`default_nettype none
module packed_shift_right_unit_tb;
    import psru_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, issue = 1'b0, src_is_mem = 1'b0;
    logic emulation_bit = 1'b0, task_switched_flag = 1'b0;
    logic float_pending = 1'b0, protected_mode = 1'b1, seg_is_stack = 1'b0;
    logic seg_limit_bad = 1'b0, page_miss = 1'b0, unaligned = 1'b0;
    logic [7:0] opcode = 8'h0, immediate_count = 8'h0;
    logic [2:0] modrm_reg = 3'h0, dest_idx = 3'h0, wr_idx;
    logic [63:0] dest_val = 64'h0, src_val = 64'h0, wr_data;
    logic [31:0] mem_eaddr = 32'h0, fault_code;
    logic done, wr_en, fault, fault_has_code;
    logic [7:0] fault_vec;
    logic [1:0] cpl = 2'h3;
    logic align_check_en = 1'b1;
    int failures = 0, n_checks = 0;
    // ------------------------------------------------------------
    // instances, clock, shared tasks
    // ------------------------------------------------------------
    psru_top i_dut (.clk, .arst_n, .issue, .opcode, .modrm_reg, .dest_idx,
        .dest_val, .src_val, .immediate_count, .src_is_mem, .emulation_bit,
        .task_switched_flag, .float_pending, .protected_mode,
        .seg_limit_bad, .seg_is_stack, .page_miss, .page_code(32'hC0DE0005),
        .unaligned, .align_check_en, .cpl, .mem_eaddr, .done,
        .wr_en, .wr_idx, .wr_data, .fault, .fault_vec, .fault_has_code,
        .fault_code);
    psru_rf_model i_rf (.clk, .arst_n, .wr_en, .wr_idx, .wr_data);
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        n_checks++;
        if (s !== e)
        begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic run(input logic [7:0] opc, input logic [2:0] rg,
        input logic [63:0] dv, input logic [63:0] sv, input logic [7:0] im,
        input logic [8:0] f, input logic [31:0] ea);
        @(posedge clk);
        issue <= 1'b1;
        {opcode, modrm_reg, dest_val, src_val, immediate_count} <=
            {opc, rg, dv, sv, im};
        {protected_mode, src_is_mem, emulation_bit, task_switched_flag,
         float_pending, seg_limit_bad, seg_is_stack, page_miss,
         unaligned} <= f;
        mem_eaddr <= ea;
        dest_idx <= dest_idx + 3'h1;
        @(posedge clk);
        issue <= 1'b0;
        #1;
        chk(64'(done), 64'h1);
    endtask
    function automatic logic [63:0] ref_sh(int w, bit ar, logic [63:0] v,
                                           logic [63:0] c);
        logic [63:0] r, m, e;
        int n;
        r = 64'h0;
        m = ~(64'hFFFF_FFFF_FFFF_FFFF << w);
        n = (c > 64'(w)) ? w : int'(c);
        for (int i = 0; i < 64 / w; i++)
        begin
            e = $signed(v << (64 - w * (i + 1))) >>> (64 - w);
            if (ar)
                e = $signed(e) >>> n;
            else
                e = (e & m) >> n;
            r = r | ((e & m) << (w * i));
        end
        return r;
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_walk();
        run(8'hE1, 3'h0, 64'h8000_0001_7FFF_0004, 64'h1, 8'h0, 9'h100, 0);
        chk(wr_data, 64'hC000_0000_3FFF_0002);
        chk(64'(wr_idx), 64'(dest_idx));
        @(posedge clk);
        #1;
        chk(i_rf.regs_q[dest_idx], 64'hC000_0000_3FFF_0002);
    endtask
    task automatic t_forms();
        logic [7:0] opc[10] = '{8'hE1, 8'hE2, 8'hD1, 8'hD2, 8'hD3,
                                8'h71, 8'h72, 8'h71, 8'h72, 8'h73};
        logic [2:0] rg[10] = '{0, 0, 0, 0, 0, 4, 4, 2, 2, 2};
        int wd[10] = '{16, 32, 16, 32, 64, 16, 32, 16, 32, 64};
        logic [63:0] cs[5];
        logic [63:0] dv;
        for (int i = 0; i < 10; i++)
        begin
            cs = '{0, 1, wd[i] - 1, wd[i], 255};
            for (int j = 0; j < 5; j++)
            begin
                dv = j[0] ? 64'h8001_7FFE_F00F_0FF0 : 64'h7FFE_8001_0FF0_F00F;
                run(opc[i], rg[i], dv, (i < 5) ? cs[j] : 64'h3,
                    (i < 5) ? 8'h3 : cs[j][7:0], 9'h100, 0);
                chk(wr_data, ref_sh(wd[i], i < 2 || i == 5 || i == 6, dv,
                    cs[j]));
            end
        end
        run(8'hD1, 3'h0, 64'hFFFF_0001_8000_7FFF, 64'h1_0000_0000, 8'h3,
            9'h100, 0);
        chk(wr_data, 64'h0);
        run(8'hE2, 3'h0, 64'h8000_0001_7FFF_0004, 64'h8000_0000_0000_0001,
            8'h3, 9'h100, 0);
        chk(wr_data, 64'hFFFF_FFFF_0000_0000);
    endtask
    task automatic t_faults();
        logic [8:0] ft[10] = '{9'h140, 9'h160, 9'h120, 9'h110, 9'h188,
                               9'h18C, 9'h182, 9'h181, 9'h080, 9'h100};
        logic [7:0] fv[10] = '{8'h06, 8'h06, 8'h07, 8'h10, 8'h0D, 8'h0C,
                               8'h0E, 8'h11, 8'h0D, 8'h06};
        for (int i = 0; i < 10; i++)
        begin
            run((i == 9) ? 8'hD5 : 8'hE2, 3'h0, 64'h1234, 64'h1, 8'h0,
                ft[i], 32'h0000_FFF9);
            chk({fault, wr_en, fault_vec}, {2'b10, fv[i]});
            chk(64'(fault_has_code), 64'((i > 3) && (i < 8)));
            if (i > 3 && i < 8)
                chk(64'(fault_code), (i == 6) ? 64'hC0DE0005 : 64'h0);
        end
        run(8'hE2, 3'h0, 64'h1234, 64'h1, 8'h0, 9'h080, 32'h0000_FFF8);
        chk(64'({fault, wr_en}), 64'h1);
        chk(wr_data, 64'h091A);
        // alignment fault only at user privilege with checking enabled
        @(posedge clk);
        cpl <= 2'h0;
        run(8'hE2, 3'h0, 64'h1234, 64'h1, 8'h0, 9'h181, 32'h0);
        chk(64'({fault, wr_en}), 64'h1);
        @(posedge clk);
        cpl <= 2'h3;
        align_check_en <= 1'b0;
        run(8'hE2, 3'h0, 64'h1234, 64'h1, 8'h0, 9'h181, 32'h0);
        chk(64'({fault, wr_en}), 64'h1);
        @(posedge clk);
        align_check_en <= 1'b1;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_walk();
        t_forms();
        t_faults();
        wrap_up();
    end
    initial
    begin
        #40000;
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
